// *** rtl/apwm_top.sv ***
// Two-axis pulse width modulated output with a Wishbone register slave.
// Behaviour
// - Axis index 0 or 1 accepted; other values raise operand fault, nothing starts.
// - Pulse train runs on the chosen axis only while start stays high.
// - Period equals programmed cycle in milliseconds, range 1 to 20000.
// - Off fraction of each period equals programmed off percentage, 0 to 100.
// - Axis position count stays unchanged while modulated output is active.
// - Steady-rate and in-operation bits of the axis set while active.
// - Other motion commands and travel limits are ignored while output runs.
// - Halt and urgent halt are ignored; dropping start stops the output.
// - Cycle changes during a running output do not affect it.
// - Start refused on an axis already operating or in fault.
//
// Added by the designer: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "apwm_defines.svh"
module apwm_top #(
  parameter int TICK_CYCLES = `APWM_TICK_CYCLES
) (
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [31:0] ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O,
  input  wire logic [1:0]  MOTION_BUSY,
  input  wire logic [1:0]  POS_STEP,
  input  wire logic [1:0]  LIMIT_HIT,
  output logic      [1:0]  AXIS_OUT
);
  // ==========================================================
  // Register state
  logic [15:0] ctrl_q, ctrl_d;
  logic [15:0] cyc_q, cyc_d;
  logic [15:0] offp_q, offp_d;
  logic        opf_q, opf_d;
  logic        ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic [31:0] pos_q [2];
  logic [31:0] pos_d [2];
  logic        lim_q [2];
  logic        lim_d [2];

  // ==========================================================
  // Modulator state
  apwm_pkg::apwm_state_t st_q, st_d;
  logic        ax_q, ax_d;
  logic [15:0] on_ms_q, on_ms_d;
  logic [15:0] per_ms_q, per_ms_d;
  logic [15:0] ms_q, ms_d;
  logic [1:0]  out_q, out_d;
  logic        tick;
  logic        start_rise;
  logic        start_q, start_d;
  logic        active;
  logic        wr;
  logic [1:0]  fault;
  logic [31:0] on_prod;

  assign wr       = CYC_I && STB_I && WE_I && !ack_q;
  assign active   = (st_q != apwm_pkg::APWM_IDLE) && (st_q != apwm_pkg::APWM_HOLD);
  assign fault[0] = ctrl_q[`APWM_CTRL_FAULT0];
  assign fault[1] = ctrl_q[`APWM_CTRL_FAULT1];
  assign start_rise = ctrl_q[`APWM_CTRL_START] && !start_q;
  assign on_prod  = 32'(cyc_q) * 32'(16'h0064 - offp_q);

  apwm_tick #(.DIV(TICK_CYCLES)) u_tick (
    .CLK   (CLK),
    .NRST  (NRST),
    .clear (start_rise),
    .tick  (tick)
  );

  // ==========================================================
  // Wishbone slave, one wait state, ack drops after one cycle
  always_comb
  begin
    ctrl_d = ctrl_q;
    cyc_d  = cyc_q;
    offp_d = offp_q;
    ack_d  = CYC_I && STB_I && !ack_q;
    dat_d  = dat_q;
    // Halt, urgent halt and fault-clear bits stand for one cycle after their write, then clear.
    // Halt has no effect while modulating.
    // halt ignored here
    ctrl_d[`APWM_CTRL_HALT]  = 1'b0;
    ctrl_d[`APWM_CTRL_UHALT] = 1'b0;
    ctrl_d[`APWM_CTRL_FCLR]  = 1'b0;
    if (wr && ADR_I == `APWM_ADR_CTRL)
    begin
      if (SEL_I[0])
        ctrl_d[7:0] = DAT_I[7:0];
      if (SEL_I[1])
        ctrl_d[15:8] = DAT_I[15:8];
    end
    if (wr && ADR_I == `APWM_ADR_CYCLE)
    begin
      if (SEL_I[0])
        cyc_d[7:0] = DAT_I[7:0];
      if (SEL_I[1])
        cyc_d[15:8] = DAT_I[15:8];
      if (SEL_I[2])
        offp_d[7:0] = DAT_I[23:16];
      if (SEL_I[3])
        offp_d[15:8] = DAT_I[31:24];
    end
    if (CYC_I && STB_I && !WE_I && !ack_q)
    begin
      unique case (ADR_I)
        `APWM_ADR_CTRL:   dat_d = {16'h0000, ctrl_q};
        `APWM_ADR_CYCLE:  dat_d = {offp_q, cyc_q};
        `APWM_ADR_STATUS: dat_d = {23'h000000, opf_q, lim_q[1], lim_q[0],
                                   active && ax_q,
                                   active && !ax_q, active && ax_q,
                                   active && !ax_q, out_q};
        `APWM_ADR_POS0:   dat_d = pos_q[0];
        `APWM_ADR_POS1:   dat_d = pos_q[1];
        default:          dat_d = 32'h0000_0000;
      endcase
    end
  end

  assign ACK_O = ack_q;
  assign DAT_O = dat_q;

  // ==========================================================
  // Position counters and limit latches
  always_comb
  begin
    for (int i = 0; i < `APWM_NUM_AXES; i++)
    begin
      pos_d[i] = pos_q[i];
      lim_d[i] = lim_q[i];
      if (!(active && ax_q == 1'(i)) && POS_STEP[i])
        pos_d[i] = pos_q[i] + 32'h0000_0001;
      if (!(active && ax_q == 1'(i)) && LIMIT_HIT[i])
        lim_d[i] = 1'b1;
    end
  end

  // ==========================================================
  // Modulator sequencing
  always_comb
  begin
    st_d     = st_q;
    ax_d     = ax_q;
    on_ms_d  = on_ms_q;
    per_ms_d = per_ms_q;
    ms_d     = ms_q;
    out_d    = out_q;
    opf_d    = opf_q;
    start_d  = ctrl_q[`APWM_CTRL_START];
    if (ctrl_q[`APWM_CTRL_FCLR])
      opf_d = 1'b0;
    unique case (st_q)
      apwm_pkg::APWM_IDLE:
      begin
        out_d = 2'b00;
        if (start_rise)
        begin
          if (ctrl_q[7:1] > 7'h01)
            opf_d = 1'b1;
          else if (MOTION_BUSY[ctrl_q[`APWM_CTRL_AXIS]] ||
                   fault[ctrl_q[`APWM_CTRL_AXIS]] ||
                   cyc_q < `APWM_CYCLE_MIN || cyc_q > `APWM_CYCLE_MAX ||
                   offp_q > `APWM_OFF_MAX)
            st_d = apwm_pkg::APWM_HOLD;
          else
          begin
            ax_d     = ctrl_q[`APWM_CTRL_AXIS];
            per_ms_d = cyc_q;
            on_ms_d  = 16'(on_prod / 32'h0000_0064);
            ms_d     = 16'h0000;
            st_d     = (16'(on_prod / 32'h0000_0064) == 16'h0000) ?
                       apwm_pkg::APWM_OFF : apwm_pkg::APWM_ON;
          end
        end
        else if (ctrl_q[`APWM_CTRL_START])
          st_d = apwm_pkg::APWM_HOLD;
      end
      apwm_pkg::APWM_ON, apwm_pkg::APWM_OFF:
      begin
        out_d        = 2'b00;
        out_d[ax_q]  = (st_q == apwm_pkg::APWM_ON);
        if (tick)
        begin
          ms_d = ms_q + 16'h0001;
          if (ms_q + 16'h0001 >= per_ms_q)
          begin
            ms_d = 16'h0000;
            st_d = (on_ms_q == 16'h0000) ? apwm_pkg::APWM_OFF
                                         : apwm_pkg::APWM_ON;
          end
          else if (ms_q + 16'h0001 >= on_ms_q)
            st_d = apwm_pkg::APWM_OFF;
        end
        if (!ctrl_q[`APWM_CTRL_START])
        begin
          st_d  = apwm_pkg::APWM_IDLE;
          out_d = 2'b00;
        end
      end
      apwm_pkg::APWM_HOLD:
      begin
        out_d = 2'b00;
        if (!ctrl_q[`APWM_CTRL_START])
          st_d = apwm_pkg::APWM_IDLE;
      end
    endcase
  end

  assign AXIS_OUT = out_q;

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      ctrl_q   <= 16'h0000;
      cyc_q    <= 16'h0001;
      offp_q   <= 16'h0000;
      opf_q    <= 1'b0;
      ack_q    <= 1'b0;
      dat_q    <= 32'h0000_0000;
      st_q     <= apwm_pkg::APWM_IDLE;
      ax_q     <= 1'b0;
      on_ms_q  <= 16'h0000;
      per_ms_q <= 16'h0001;
      ms_q     <= 16'h0000;
      out_q    <= 2'b00;
      start_q  <= 1'b0;
      pos_q    <= '{32'h0000_0000, 32'h0000_0000};
      lim_q    <= '{1'b0, 1'b0};
    end
    else
    begin
      ctrl_q   <= ctrl_d;
      cyc_q    <= cyc_d;
      offp_q   <= offp_d;
      opf_q    <= opf_d;
      ack_q    <= ack_d;
      dat_q    <= dat_d;
      st_q     <= st_d;
      ax_q     <= ax_d;
      on_ms_q  <= on_ms_d;
      per_ms_q <= per_ms_d;
      ms_q     <= ms_d;
      out_q    <= out_d;
      start_q  <= start_d;
      pos_q    <= pos_d;
      lim_q    <= lim_d;
    end
  end

  // ==========================================================
  // Assertions
  // bad axis flags fault
  a_bad_axis_fault: assert property (@(posedge CLK)
    disable iff (!NRST)
    (st_q == apwm_pkg::APWM_IDLE && start_rise && ctrl_q[7:1] > 7'h01)
    |=> opf_q && !active) else $error("bad axis did not fault");
  a_stop_on_drop: assert property (@(posedge CLK)
    disable iff (!NRST)
    (active && !ctrl_q[`APWM_CTRL_START]) |=> out_q == 2'b00 && !active)
    else $error("output kept after start dropped");
  a_pos_frozen: assert property (@(posedge CLK)
    disable iff (!NRST)
    (active && $past(active) && ax_q == 1'b0) |-> $stable(pos_q[0]))
    else $error("position changed while active");
  a_refuse_busy: assert property (@(posedge CLK)
    disable iff (!NRST)
    (st_q == apwm_pkg::APWM_IDLE && start_rise && ctrl_q[7:1] <= 7'h01 &&
     MOTION_BUSY[ctrl_q[`APWM_CTRL_AXIS]]) |=> !active)
    else $error("started on a busy axis");
  a_period_held: assert property (@(posedge CLK)
    disable iff (!NRST)
    (active && $past(active)) |-> $stable(per_ms_q))
    else $error("period changed while running");
  a_on_first: assert property (@(posedge CLK)
    disable iff (!NRST)
    ($rose(active) && on_ms_q != 16'h0000) |-> st_q == apwm_pkg::APWM_ON)
    else $error("period did not start on");
  a_full_off: assert property (@(posedge CLK)
    disable iff (!NRST)
    (active && on_ms_q == 16'h0000) |=> out_q == 2'b00)
    else $error("output on with full off duty");
  a_one_axis: assert property (@(posedge CLK)
    disable iff (!NRST)
    out_q != 2'b11) else $error("both axes driven");
  a_on_le_period: assert property (@(posedge CLK)
    disable iff (!NRST)
    active |-> on_ms_q <= per_ms_q) else $error("on phase exceeds period");

  c_run: cover property (@(posedge CLK) disable iff (!NRST)
    st_q == apwm_pkg::APWM_ON ##[1:1000] st_q == apwm_pkg::APWM_OFF);
  c_fault: cover property (@(posedge CLK) disable iff (!NRST) $rose(opf_q));
  c_hold: cover property (@(posedge CLK) disable iff (!NRST)
    st_q == apwm_pkg::APWM_HOLD);
endmodule
`default_nettype wire

// *** rtl/apwm_defines.svh ***
// Timing constants, register addresses and bit positions for the axis pulse modulator.
`ifndef APWM_DEFINES_SVH
`define APWM_DEFINES_SVH

`define APWM_CLK_HZ        125000000
`define APWM_TICK_MS       1
`define APWM_TICK_CYCLES   ((`APWM_CLK_HZ / 1000) * `APWM_TICK_MS)
`define APWM_CYCLE_MIN     16'h0001
`define APWM_CYCLE_MAX     16'h4E20
`define APWM_OFF_MAX       16'h0064
`define APWM_NUM_AXES      2

`define APWM_ADR_CTRL      32'h0000_0000
`define APWM_ADR_CYCLE     32'h0000_0004
`define APWM_ADR_STATUS    32'h0000_0008
`define APWM_ADR_POS0      32'h0000_000C
`define APWM_ADR_POS1      32'h0000_0010

`define APWM_CTRL_START    0
`define APWM_CTRL_AXIS     1
`define APWM_CTRL_FCLR     2
`define APWM_CTRL_HALT     3
`define APWM_CTRL_UHALT    4
`define APWM_CTRL_FAULT0   8
`define APWM_CTRL_FAULT1   9
`define APWM_CYC_LSB       0
`define APWM_OFF_LSB       16

`define APWM_ST_OUT0       0
`define APWM_ST_OUT1       1
`define APWM_ST_OPER0      2
`define APWM_ST_OPER1      3
`define APWM_ST_STEADY0    4
`define APWM_ST_STEADY1    5
`define APWM_ST_OPFAULT    8

`endif

// *** rtl/apwm_pkg.sv ***
// Types shared by the axis pulse modulator.
package apwm_pkg;
  typedef enum logic [1:0]
  {
    APWM_IDLE = 2'b00,
    APWM_ON   = 2'b01,
    APWM_OFF  = 2'b11,
    APWM_HOLD = 2'b10
  } apwm_state_t;
endpackage

// *** rtl/apwm_tick.sv ***
// Millisecond tick divider for the axis pulse modulator.
`timescale 1ns/1ps
`default_nettype none
module apwm_tick #(
  parameter int DIV = 125000
) (
  input  wire logic CLK,
  input  wire logic NRST,
  input  wire logic clear,
  output logic      tick
);
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;

  always_comb
  begin
    tick  = (cnt_q == 32'(DIV - 1));
    cnt_d = (clear || tick) ? 32'h0000_0000 : cnt_q + 32'h0000_0001;
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      cnt_q <= 32'h0000_0000;
    else
      cnt_q <= cnt_d;
  end
endmodule
`default_nettype wire

// *** test/apwm_load.sv ***
// Load model that times the on phase and the period of one modulated output.
`timescale 1ns/1ps
`default_nettype none
module apwm_load (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        drive,
  output logic      [31:0] on_len,
  output logic      [31:0] per_len
);
  logic        prev;
  logic [31:0] cnt;
  // ==========
  // Timing
  // Clocks are counted from each rising edge of the drive.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      prev    <= 1'b0;
      cnt     <= 32'h0;
      on_len  <= 32'h0;
      per_len <= 32'h0;
    end
    else
    begin
      prev <= drive;
      cnt  <= (drive && !prev) ? 32'h1 : cnt + 32'h1;
      if (drive && !prev)
        per_len <= cnt;
      if (!drive && prev)
        on_len <= cnt;
    end
  end
endmodule
`default_nettype wire

// *** test/apwm_tb.sv ***
// Self-checking bench for the axis pulse width modulator.
`timescale 1ns/1ps
`default_nettype none
`include "apwm_defines.svh"
module axis_pulse_width_modulator_tb;
  localparam int TK = 10;
  logic        clk;
  logic        nrst;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [31:0] adr;
  logic [31:0] wdat;
  logic [31:0] dout;
  logic [31:0] rv;
  logic        ack;
  logic [1:0]  busy;
  logic [1:0]  step;
  logic [1:0]  limit;
  logic [1:0]  axis_out;
  logic [31:0] on_len [2];
  logic [31:0] per_len [2];
  int          miscompares;
  int          checked;

  apwm_top #(.TICK_CYCLES(TK)) uut (.CLK(clk), .NRST(nrst), .CYC_I(cyc),
    .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(4'hF), .DAT_I(wdat),
    .DAT_O(dout), .ACK_O(ack), .MOTION_BUSY(busy), .POS_STEP(step),
    .LIMIT_HIT(limit), .AXIS_OUT(axis_out));
  apwm_load load0 (.clk(clk), .nrst(nrst), .drive(axis_out[0]),
    .on_len(on_len[0]), .per_len(per_len[0]));
  apwm_load load1 (.clk(clk), .nrst(nrst), .drive(axis_out[1]),
    .on_len(on_len[1]), .per_len(per_len[1]));

  // ==========
  // Common tasks
  task automatic stop_test;
    if (miscompares == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [31:0] a,
                    input logic [31:0] d);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    // Acknowledge and read data are taken at the same rising edge.
    @(posedge clk);
    while (ack !== 1'b1)
      @(posedge clk);
    rv = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] m,
                    input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rv & m, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  // ==========
  // Scenarios
  task automatic t_reset;
    rd(`APWM_ADR_CYCLE, 32'hFFFFFFFF, 32'h00000001);
    rd(`APWM_ADR_STATUS, 32'hFFFFFFFF, 32'h0);
    rd(32'h00000040, 32'hFFFFFFFF, 32'h0);
  endtask

  task automatic t_run;
    wb(1'b1, `APWM_ADR_CYCLE, 32'h00280005);
    wb(1'b1, `APWM_ADR_CTRL, 32'h1);
    idle(130);
    chk(on_len[0], 32'h1E);
    chk(per_len[0], 32'h32);
    rd(`APWM_ADR_STATUS, 32'h13C, 32'h14);
    @(posedge clk);
    step  <= 2'b01;
    limit <= 2'b01;
    @(posedge clk);
    step  <= 2'b00;
    wb(1'b1, `APWM_ADR_CYCLE, 32'h00000002);
    wb(1'b1, `APWM_ADR_CTRL, 32'h19);
    idle(110);
    chk(per_len[0], 32'h32);
    chk(on_len[0], 32'h1E);
    rd(`APWM_ADR_STATUS, 32'h3C, 32'h14);
    rd(`APWM_ADR_POS0, 32'hFFFFFFFF, 32'h0);
    wb(1'b1, `APWM_ADR_CTRL, 32'h0);
    limit <= 2'b00;
    idle(2);
    chk({30'h0, axis_out}, 32'h0);
    rd(`APWM_ADR_STATUS, 32'h3F, 32'h0);
    rd(`APWM_ADR_STATUS, 32'hC0, 32'h0);
    step <= 2'b01;
    limit <= 2'b01;
    @(posedge clk);
    step <= 2'b00;
    limit <= 2'b00;
    rd(`APWM_ADR_POS0, 32'hFFFFFFFF, 32'h1);
    rd(`APWM_ADR_STATUS, 32'hC0, 32'h40);
  endtask

  task automatic t_bad_axis;
    wb(1'b1, `APWM_ADR_CTRL, 32'h5);
    idle(30);
    chk({30'h0, axis_out}, 32'h0);
    rd(`APWM_ADR_STATUS, 32'h10C, 32'h100);
    wb(1'b1, `APWM_ADR_CTRL, 32'h0);
    wb(1'b1, `APWM_ADR_CTRL, 32'h4);
    rd(`APWM_ADR_STATUS, 32'h100, 32'h0);
  endtask

  task automatic t_refuse;
    busy <= 2'b10;
    wb(1'b1, `APWM_ADR_CYCLE, 32'h00320002);
    wb(1'b1, `APWM_ADR_CTRL, 32'h3);
    idle(40);
    chk({30'h0, axis_out}, 32'h0);
    wb(1'b1, `APWM_ADR_CTRL, 32'h0);
    busy <= 2'b00;
    wb(1'b1, `APWM_ADR_CTRL, 32'h101);
    idle(40);
    chk({30'h0, axis_out}, 32'h0);
    wb(1'b1, `APWM_ADR_CTRL, 32'h0);
    wb(1'b1, `APWM_ADR_CTRL, 32'h3);
    idle(70);
    chk(on_len[1], 32'hA);
    chk(per_len[1], 32'h14);
    rd(`APWM_ADR_STATUS, 32'h3C, 32'h28);
    step <= 2'b11;
    @(posedge clk);
    step <= 2'b00;
    rd(`APWM_ADR_POS1, 32'hFFFFFFFF, 32'h0);
    rd(`APWM_ADR_POS0, 32'hFFFFFFFF, 32'h2);
    wb(1'b1, `APWM_ADR_CTRL, 32'h0);
  endtask

  task automatic t_limits;
    wb(1'b1, `APWM_ADR_CYCLE, 32'h00640001);
    wb(1'b1, `APWM_ADR_CTRL, 32'h1);
    idle(30);
    chk({30'h0, axis_out}, 32'h0);
    rd(`APWM_ADR_STATUS, 32'h4, 32'h4);
    wb(1'b1, `APWM_ADR_CTRL, 32'h0);
    wb(1'b1, `APWM_ADR_CYCLE, 32'h0);
    wb(1'b1, `APWM_ADR_CTRL, 32'h1);
    idle(30);
    rd(`APWM_ADR_STATUS, 32'h5, 32'h0);
    wb(1'b1, `APWM_ADR_CTRL, 32'h0);
  endtask

  // ==========
  // Clock, watchdog and main sequence
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    miscompares++;
    stop_test();
  end

  initial
  begin
    miscompares = 0;
    checked = 0;
    nrst = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 32'h0;
    wdat = 32'h0;
    busy = 2'b00;
    step = 2'b00;
    limit = 2'b00;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_run();
    t_bad_axis();
    t_refuse();
    t_limits();
    stop_test();
  end
endmodule
`default_nettype wire
